// >>> shared/dnt_cfg.svh
// Offsets, field positions, reset values and widths of the downconverter tuning registers.
// Assumes byte-wide registers on a plain strobe port with a 12-bit byte address.
`ifndef DNT_CFG_SVH
`define DNT_CFG_SVH

`define DNT_ADDR_W        12
`define DNT_DATA_W        8
`define DNT_WORD_W        48
`define DNT_WORD_BYTES    6

`define DNT_PATH_SEL_ADDR 12'h331
`define DNT_TW_B0_ADDR    12'h334
`define DNT_TW_B1_ADDR    12'h335
`define DNT_TW_B2_ADDR    12'h336
`define DNT_TW_B3_ADDR    12'h337
`define DNT_TW_B4_ADDR    12'h338
`define DNT_TW_B5_ADDR    12'h33A
`define DNT_PO_B0_ADDR    12'h33D
`define DNT_PO_B1_ADDR    12'h33E
`define DNT_PO_B2_ADDR    12'h33F
`define DNT_PO_B3_ADDR    12'h340
`define DNT_PO_B4_ADDR    12'h341
`define DNT_PO_B5_ADDR    12'h342

`define DNT_Q_SEL_BIT     2
`define DNT_I_SEL_BIT     0
`define DNT_PATH_SEL_MASK 8'h05
`define DNT_PATH_SEL_RST  8'h05
`define DNT_BYTE_RST      8'h00
`define DNT_READ_IDLE     8'h00

`define DNT_SAMPLE_W      14

`endif

// >>> shared/dnt_pkg.sv
// Types shared by the tuning register bank and its oscillator.
// Assumes the constants of dnt_cfg.svh are included where numbers are needed.
package dnt_pkg;

  typedef enum logic {
    dnt_src_a = 1'b0,
    dnt_src_b = 1'b1
  } dnt_src_t;

  typedef logic [47:0] dnt_word_t;
  typedef logic [7:0]  dnt_byte_t;

endpackage : dnt_pkg

// >>> core/dnt_byte_reg.sv
// One byte-wide software register with a parameterised reset value and write mask.
// Assumes a synchronous write enable and an active-low asynchronous reset already synchronised.
`timescale 1ns/10ps

module dnt_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 wr_en,
  input  wire dnt_pkg::dnt_byte_t   wdata,
  output      dnt_pkg::dnt_byte_t   q
);

  dnt_pkg::dnt_byte_t q_q;
  dnt_pkg::dnt_byte_t q_d;

  // Masked bits keep reading as their reset value, which is zero for reserved bits
  assign q_d = wr_en ? ((wdata & WR_MASK) | (RST_VAL & ~WR_MASK)) : q_q;
  assign q   = q_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= RST_VAL;
    end else begin
      q_q <= q_d;
    end
  end

endmodule : dnt_byte_reg

// >>> core/dnt_phase_acc.sv
// Numerically controlled oscillator phase: accumulator plus phase offset.
// Assumes one sample per clock and tuning and offset words held stable by the register bank.
`timescale 1ns/10ps

module dnt_phase_acc #(
  parameter int WORD_W = 48
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [WORD_W-1:0] tune_word,
  input  wire logic [WORD_W-1:0] phase_offs,
  output      logic [WORD_W-1:0] mix_phase
);

  logic [WORD_W-1:0] acc_q;
  logic [WORD_W-1:0] acc_d;
  logic [WORD_W-1:0] phase_q;
  logic [WORD_W-1:0] phase_d;

  // Plain binary add wraps modulo 2^WORD_W, so a signed word tunes negative frequencies
  assign acc_d     = acc_q + tune_word;
  assign phase_d   = acc_q + phase_offs;
  assign mix_phase = phase_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q   <= '0;
      phase_q <= '0;
    end else begin
      acc_q   <= acc_d;
      phase_q <= phase_d;
    end
  end

  property p_acc_step;
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> acc_q == WORD_W'($past(acc_q) + $past(tune_word));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator did not step by tuning word");

endmodule : dnt_phase_acc

// >>> core/dnt_top.sv
// Register bank and oscillator of one downconverter channel.
// Assumes byte registers on a strobe port, channel samples synchronous to clk, one sample per clock.
`timescale 1ns/10ps
`include "dnt_cfg.svh"

module dnt_top #(
  parameter int SAMPLE_W = `DNT_SAMPLE_W
) (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic [`DNT_ADDR_W-1:0] reg_addr,
  input  wire logic [`DNT_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output      logic [`DNT_DATA_W-1:0] reg_rdata,
  input  wire logic [SAMPLE_W-1:0]    chan_a_sample,
  input  wire logic [SAMPLE_W-1:0]    chan_b_sample,
  output      logic [SAMPLE_W-1:0]    i_path_sample,
  output      logic [SAMPLE_W-1:0]    q_path_sample,
  output      logic [`DNT_WORD_W-1:0] tune_word,
  output      logic [`DNT_WORD_W-1:0] mix_phase
);

  localparam int NB = `DNT_WORD_BYTES;

  localparam logic [`DNT_ADDR_W-1:0] TW_ADDR [NB] = '{
    `DNT_TW_B0_ADDR, `DNT_TW_B1_ADDR, `DNT_TW_B2_ADDR,
    `DNT_TW_B3_ADDR, `DNT_TW_B4_ADDR, `DNT_TW_B5_ADDR
  };
  localparam logic [`DNT_ADDR_W-1:0] PO_ADDR [NB] = '{
    `DNT_PO_B0_ADDR, `DNT_PO_B1_ADDR, `DNT_PO_B2_ADDR,
    `DNT_PO_B3_ADDR, `DNT_PO_B4_ADDR, `DNT_PO_B5_ADDR
  };

  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;

  // The first stage feeds only the second, so release is glitch-free for the bank
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Address decode
  logic                     sel_hit;
  logic [NB-1:0]            tw_hit;
  logic [NB-1:0]            po_hit;
  logic                     sel_wr;
  logic [NB-1:0]            tw_wr;
  logic [NB-1:0]            po_wr;
  dnt_pkg::dnt_byte_t       sel_byte;
  dnt_pkg::dnt_byte_t       tw_byte [NB];
  dnt_pkg::dnt_byte_t       po_byte [NB];
  dnt_pkg::dnt_word_t       tw_word;
  dnt_pkg::dnt_word_t       po_word;

  assign sel_hit = (reg_addr == `DNT_PATH_SEL_ADDR);
  assign sel_wr  = reg_wr & sel_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_bytes
      assign tw_hit[gi] = (reg_addr == TW_ADDR[gi]);
      assign po_hit[gi] = (reg_addr == PO_ADDR[gi]);
      assign tw_wr[gi]  = reg_wr & tw_hit[gi];
      assign po_wr[gi]  = reg_wr & po_hit[gi];

      dnt_byte_reg #(
        .RST_VAL (`DNT_BYTE_RST),
        .WR_MASK (8'hFF)
      ) u_tw_byte (
        .clk   (clk),
        .rst_n (rst_sync_q),
        .wr_en (tw_wr[gi]),
        .wdata (reg_wdata),
        .q     (tw_byte[gi])
      );

      dnt_byte_reg #(
        .RST_VAL (`DNT_BYTE_RST),
        .WR_MASK (8'hFF)
      ) u_po_byte (
        .clk   (clk),
        .rst_n (rst_sync_q),
        .wr_en (po_wr[gi]),
        .wdata (reg_wdata),
        .q     (po_byte[gi])
      );

      // Byte index equals significance: lowest address carries bits 7:0
      assign tw_word[8*gi +: 8] = tw_byte[gi];
      assign po_word[8*gi +: 8] = po_byte[gi];
    end
  endgenerate

  // Reserved bits 7:3 and 1 are masked out and read as zero
  dnt_byte_reg #(
    .RST_VAL (`DNT_PATH_SEL_RST),
    .WR_MASK (`DNT_PATH_SEL_MASK)
  ) u_path_sel (
    .clk   (clk),
    .rst_n (rst_sync_q),
    .wr_en (sel_wr),
    .wdata (reg_wdata),
    .q     (sel_byte)
  );

  // Path routing
  dnt_pkg::dnt_src_t      i_src;
  dnt_pkg::dnt_src_t      q_src;
  logic [SAMPLE_W-1:0]    i_path_d;
  logic [SAMPLE_W-1:0]    q_path_d;
  logic [SAMPLE_W-1:0]    i_path_q;
  logic [SAMPLE_W-1:0]    q_path_q;

  assign i_src    = dnt_pkg::dnt_src_t'(sel_byte[`DNT_I_SEL_BIT]);
  assign q_src    = dnt_pkg::dnt_src_t'(sel_byte[`DNT_Q_SEL_BIT]);
  assign i_path_d = (i_src == dnt_pkg::dnt_src_b) ? chan_b_sample : chan_a_sample;
  assign q_path_d = (q_src == dnt_pkg::dnt_src_b) ? chan_b_sample : chan_a_sample;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      i_path_q <= '0;
      q_path_q <= '0;
    end else begin
      i_path_q <= i_path_d;
      q_path_q <= q_path_d;
    end
  end

  assign i_path_sample = i_path_q;
  assign q_path_sample = q_path_q;

  // Oscillator
  // Bytes take effect one at a time; software sees intermediate frequencies while retuning
  logic [`DNT_WORD_W-1:0] tune_word_q;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tune_word_q <= '0;
    end else begin
      tune_word_q <= tw_word;
    end
  end

  assign tune_word = tune_word_q;

  dnt_phase_acc #(
    .WORD_W (`DNT_WORD_W)
  ) u_nco (
    .clk        (clk),
    .rst_n      (rst_sync_q),
    .tune_word  (tw_word),
    .phase_offs (po_word),
    .mix_phase  (mix_phase)
  );

  // Read path
  dnt_pkg::dnt_byte_t rd_mux;
  dnt_pkg::dnt_byte_t tw_rd;
  dnt_pkg::dnt_byte_t po_rd;
  dnt_pkg::dnt_byte_t rdata_q;
  dnt_pkg::dnt_byte_t rdata_d;

  always_comb begin
    tw_rd = `DNT_READ_IDLE;
    po_rd = `DNT_READ_IDLE;
    for (int k = 0; k < NB; k++) begin
      if (tw_hit[k]) begin
        tw_rd = tw_byte[k];
      end
      if (po_hit[k]) begin
        po_rd = po_byte[k];
      end
    end
  end

  // Unmapped addresses read as zero; the hit sets are disjoint so an OR is enough
  assign rd_mux  = (sel_hit ? sel_byte : `DNT_READ_IDLE) | tw_rd | po_rd;
  assign rdata_d = reg_rd ? rd_mux : `DNT_READ_IDLE;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q <= `DNT_READ_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks
  property p_q_route;
    @(posedge clk) disable iff (!rst_sync_q)
      $past(rst_sync_q) |->
        q_path_sample == ($past(sel_byte[`DNT_Q_SEL_BIT]) ? $past(chan_b_sample)
                                                         : $past(chan_a_sample));
  endproperty
  a_q_route: assert property (p_q_route) else $error("Q path routed from wrong channel");

  property p_i_route;
    @(posedge clk) disable iff (!rst_sync_q)
      $past(rst_sync_q) |->
        i_path_sample == ($past(sel_byte[`DNT_I_SEL_BIT]) ? $past(chan_b_sample)
                                                         : $past(chan_a_sample));
  endproperty
  a_i_route: assert property (p_i_route) else $error("I path routed from wrong channel");

  property p_sel_reset;
    @(posedge clk)
      $rose(rst_sync_q) |-> sel_byte == `DNT_PATH_SEL_RST && tw_word == '0 && po_word == '0;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("register reset values wrong");

  property p_tw_low_write;
    @(posedge clk) disable iff (!rst_sync_q)
      (reg_wr && reg_addr == `DNT_TW_B0_ADDR) |=> tw_word[7:0] == $past(reg_wdata)
                                                  && tw_word[47:8] == $past(tw_word[47:8]);
  endproperty
  a_tw_low_write: assert property (p_tw_low_write) else $error("tuning low byte write");

  property p_tw_high_write;
    @(posedge clk) disable iff (!rst_sync_q)
      (reg_wr && reg_addr == `DNT_TW_B5_ADDR) |=> tw_word[47:40] == $past(reg_wdata)
                                                   && tw_word[39:0] == $past(tw_word[39:0]);
  endproperty
  a_tw_high_write: assert property (p_tw_high_write) else $error("tuning high byte write");

  property p_freq_step;
    @(posedge clk) disable iff (!rst_sync_q)
      $past(rst_sync_q, 3) |->
        `DNT_WORD_W'(mix_phase - $past(mix_phase)) ==
        `DNT_WORD_W'($past(tw_word, 2) + $past(po_word) - $past(po_word, 2));
  endproperty
  a_freq_step: assert property (p_freq_step) else $error("phase step differs from tuning");

  property p_po_write;
    @(posedge clk) disable iff (!rst_sync_q)
      (reg_wr && reg_addr == `DNT_PO_B5_ADDR) ##1 (!reg_wr)
        |-> po_word[47:40] == $past(reg_wdata, 1)
            || po_word[47:40] == $past(reg_wdata, 2);
  endproperty
  a_po_write: assert property (p_po_write) else $error("phase offset high byte write");

  property p_po_offset_applied;
    @(posedge clk) disable iff (!rst_sync_q)
      ($past(rst_sync_q, 2) && $stable(tw_word) && $past($stable(tw_word)) && $changed(po_word))
        |=> `DNT_WORD_W'(mix_phase - $past(mix_phase)) ==
            `DNT_WORD_W'($past(tw_word) + $past(po_word) - $past(po_word, 2));
  endproperty
  a_po_offset_applied: assert property (p_po_offset_applied) else $error("offset not applied");

  property p_acc_wrap;
    @(posedge clk) disable iff (!rst_sync_q)
      ($past(rst_sync_q, 2) && $stable(po_word) && $past($stable(po_word)))
        |-> `DNT_WORD_W'(mix_phase - $past(mix_phase)) == $past(tw_word, 2);
  endproperty
  a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator step not modular");

  property p_sel_readback;
    @(posedge clk) disable iff (!rst_sync_q)
      (reg_rd && reg_addr == `DNT_PATH_SEL_ADDR)
        |=> reg_rdata == ($past(sel_byte) & `DNT_PATH_SEL_MASK);
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("select readback wrong");

  property p_idle_read;
    @(posedge clk) disable iff (!rst_sync_q)
      !reg_rd |=> reg_rdata == `DNT_READ_IDLE;
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("read data outside read cycle");

endmodule : dnt_top

// >>> verification/tb.sv
// Self-checking bench for the downconverter tuning register bank and its oscillator.
// Assumes dnt_top and dnt_cfg.svh on the include path, 25 MHz clock, strobe register port.
`timescale 1ns/10ps
`include "dnt_cfg.svh"

module tb;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rexp;
  } dnt_row_t;

  localparam logic [47:0] TW = 48'hFEDC_BA98_7655;
  localparam logic [13:0] SA = 14'h1A5A;
  localparam logic [13:0] SB = 14'h0C3C;

  logic        clk;
  logic        resetn;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [13:0] chan_a_sample;
  logic [13:0] chan_b_sample;
  logic [13:0] i_path_sample;
  logic [13:0] q_path_sample;
  logic [47:0] tune_word;
  logic [47:0] mix_phase;
  int          err_count;
  int          n_tests;
  logic [47:0] p0;
  logic [47:0] p1;

  // Unmapped rows sit among mapped ones so decoding holes are hit in order
  dnt_row_t rows [16] = '{
    '{12'h331, 8'hFF, 8'h05}, '{12'h331, 8'h00, 8'h00}, '{12'h330, 8'hFF, 8'h00},
    '{12'h334, 8'h55, 8'h55}, '{12'h335, 8'h76, 8'h76}, '{12'h336, 8'h98, 8'h98},
    '{12'h337, 8'hBA, 8'hBA}, '{12'h338, 8'hDC, 8'hDC}, '{12'h339, 8'hAA, 8'h00},
    '{12'h33A, 8'hFE, 8'hFE}, '{12'h33E, 8'h11, 8'h11}, '{12'h33F, 8'h22, 8'h22},
    '{12'h340, 8'h33, 8'h33}, '{12'h341, 8'h44, 8'h44}, '{12'h343, 8'h77, 8'h00},
    '{12'h342, 8'h66, 8'h66}
  };
  logic [11:0] map_addr [13] = '{
    `DNT_PATH_SEL_ADDR, `DNT_TW_B0_ADDR, `DNT_TW_B1_ADDR, `DNT_TW_B2_ADDR, `DNT_TW_B3_ADDR,
    `DNT_TW_B4_ADDR, `DNT_TW_B5_ADDR, `DNT_PO_B0_ADDR, `DNT_PO_B1_ADDR, `DNT_PO_B2_ADDR,
    `DNT_PO_B3_ADDR, `DNT_PO_B4_ADDR, `DNT_PO_B5_ADDR
  };

  dnt_top u_dut (
    .clk           (clk),
    .resetn        (resetn),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .chan_a_sample (chan_a_sample),
    .chan_b_sample (chan_b_sample),
    .i_path_sample (i_path_sample),
    .q_path_sample (q_path_sample),
    .tune_word     (tune_word),
    .mix_phase     (mix_phase)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is looked at in its one valid cycle, then must fall back to idle
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(48'(reg_rdata), 48'(exp));
    @(negedge clk);
    chk(48'(reg_rdata), 48'(`DNT_READ_IDLE));
  endtask : rd

  task automatic check_defaults();
    for (int k = 0; k < 13; k++) begin
      rd(map_addr[k], (k == 0) ? `DNT_PATH_SEL_RST : `DNT_BYTE_RST);
    end
  endtask : check_defaults

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED t=%0t run did not finish in time", $time);
    final_report();
  end

  initial begin
    err_count     = 0;
    n_tests       = 0;
    resetn        = 1'b0;
    reg_addr      = 12'h000;
    reg_wdata     = 8'h00;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    chan_a_sample = SA;
    chan_b_sample = SB;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    check_defaults();
    $display("test reset_values done");

    // Write then read straight back, reserved bits and holes included
    for (int k = 0; k < 16; k++) begin
      wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr, rows[k].rexp);
    end
    $display("test row_table done");

    for (int k = 0; k < 4; k++) begin
      wr(`DNT_PATH_SEL_ADDR, {5'h00, k[1], 1'b0, k[0]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(48'(i_path_sample), 48'(k[0] ? SB : SA));
      chk(48'(q_path_sample), 48'(k[1] ? SB : SA));
    end
    $display("test path_select done");

    chk(tune_word, TW);
    @(negedge clk);
    p0 = mix_phase;
    @(negedge clk);
    p1 = mix_phase;
    chk(p1 - p0, TW);
    // Six edges pass between samples; the offset step lands once on top of them
    @(negedge clk);
    p0 = mix_phase;
    wr(`DNT_PO_B0_ADDR, 8'h10);
    repeat (4) @(posedge clk);
    @(negedge clk);
    p1 = mix_phase;
    chk(p1 - p0, TW * 48'd6 + 48'h10);
    $display("test oscillator done");

    do_reset();
    @(negedge clk);
    chk(tune_word, 48'h0);
    chk(mix_phase, 48'h0);
    check_defaults();
    $display("test mid_run_reset done");
    final_report();
  end
endmodule : tb
